/* File: hw/iftcr_bank.sv */
// tuning and calibration configuration register bank
// assumes a synchronous 8-bit register port: addr, wr_en, rd_en, wdata, rdata
`include "iftcr_regs.svh"
`default_nettype none
module iftcr_bank
  import iftcr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [8:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire iftcr_byte_t wdata,
  output iftcr_byte_t rdata,
  output logic rd_valid,
  output iftcr_mhz_t if_freq,
  output iftcr_mhz_t bandwidth,
  output iftcr_byte_t tank_inductance,
  output iftcr_byte_t lower_resonator_margin,
  output iftcr_byte_t upper_resonator_margin,
  output iftcr_byte_t tank_resonator_margin,
  output iftcr_byte_t feedback_dac_full_scale,
  output iftcr_slot_t cal_slot
);
  localparam int NREG = 10;
  localparam logic [8:0] OFS [NREG] = '{
    `IFTCR_OFS_IF_FREQ_LOW, `IFTCR_OFS_IF_FREQ_HIGH, `IFTCR_OFS_BANDWIDTH_LOW,
    `IFTCR_OFS_BANDWIDTH_HIGH, `IFTCR_OFS_TANK_INDUCTANCE, `IFTCR_OFS_LOWER_MARGIN,
    `IFTCR_OFS_UPPER_MARGIN, `IFTCR_OFS_TANK_MARGIN, `IFTCR_OFS_DAC_FULL_SCALE,
    `IFTCR_OFS_CAL_CONTROL};
  localparam iftcr_byte_t RST [NREG] = '{
    `IFTCR_RST_IF_FREQ_LOW, `IFTCR_RST_IF_FREQ_HIGH, `IFTCR_RST_BANDWIDTH_LOW,
    `IFTCR_RST_BANDWIDTH_HIGH, `IFTCR_RST_TANK_INDUCTANCE, `IFTCR_RST_LOWER_MARGIN,
    `IFTCR_RST_UPPER_MARGIN, `IFTCR_RST_TANK_MARGIN, `IFTCR_RST_DAC_FULL_SCALE,
    `IFTCR_RST_CAL_CONTROL};

  iftcr_byte_t q [NREG];
  logic [NREG-1:0] hit;

  // one cell per register
  for (genvar i = 0; i < NREG; i++) begin : g_reg
    assign hit[i] = (addr == OFS[i]);
    iftcr_cell #(
      .RST(RST[i]),
      .MASK((i == int'(IFTCR_CALC)) ? ~`IFTCR_CAL_CTRL_RSVD_MASK : 8'hff)
    ) u_cell (
      .clk(clk),
      .rstn(rstn),
      .we(wr_en && hit[i]),
      .wdata(wdata),
      .q(q[i])
    );
  end

  // read mux and field outputs
  iftcr_byte_t rdata_r;
  iftcr_byte_t rdata_nxt;
  logic rd_valid_r;
  logic rd_valid_nxt;
  iftcr_mhz_t if_freq_r;
  iftcr_mhz_t if_freq_nxt;
  iftcr_mhz_t bandwidth_r;
  iftcr_mhz_t bandwidth_nxt;
  iftcr_byte_t lind_r;
  iftcr_byte_t lind_nxt;
  iftcr_byte_t mlo_r;
  iftcr_byte_t mlo_nxt;
  iftcr_byte_t mup_r;
  iftcr_byte_t mup_nxt;
  iftcr_byte_t mtank_r;
  iftcr_byte_t mtank_nxt;
  iftcr_byte_t dacfs_r;
  iftcr_byte_t dacfs_nxt;
  iftcr_slot_t slot_r;
  iftcr_slot_t slot_nxt;

  always_comb begin
    rdata_nxt = rdata_r;
    rd_valid_nxt = rd_en;
    if (rd_en) begin
      rdata_nxt = 8'h00;
      for (int k = 0; k < NREG; k++) begin
        if (hit[k]) begin
          rdata_nxt = q[k];
        end
      end
    end
    if_freq_nxt = {q[IFTCR_IF_HI], q[IFTCR_IF_LO]};
    bandwidth_nxt = {q[IFTCR_BW_HI], q[IFTCR_BW_LO]};
    slot_nxt = q[IFTCR_CALC][`IFTCR_CAL_SLOT_MSB:`IFTCR_CAL_SLOT_LSB];
    lind_nxt = q[IFTCR_LIND];
    mlo_nxt = q[IFTCR_MLO];
    mup_nxt = q[IFTCR_MUP];
    mtank_nxt = q[IFTCR_MTANK];
    dacfs_nxt = q[IFTCR_DACFS];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
      rd_valid_r <= 1'b0;
      if_freq_r <= {`IFTCR_RST_IF_FREQ_HIGH, `IFTCR_RST_IF_FREQ_LOW};
      bandwidth_r <= {`IFTCR_RST_BANDWIDTH_HIGH, `IFTCR_RST_BANDWIDTH_LOW};
      lind_r <= `IFTCR_RST_TANK_INDUCTANCE;
      mlo_r <= `IFTCR_RST_LOWER_MARGIN;
      mup_r <= `IFTCR_RST_UPPER_MARGIN;
      mtank_r <= `IFTCR_RST_TANK_MARGIN;
      dacfs_r <= `IFTCR_RST_DAC_FULL_SCALE;
      slot_r <= 2'h0;
    end else begin
      rdata_r <= rdata_nxt;
      rd_valid_r <= rd_valid_nxt;
      if_freq_r <= if_freq_nxt;
      bandwidth_r <= bandwidth_nxt;
      lind_r <= lind_nxt;
      mlo_r <= mlo_nxt;
      mup_r <= mup_nxt;
      mtank_r <= mtank_nxt;
      dacfs_r <= dacfs_nxt;
      slot_r <= slot_nxt;
    end
  end

  assign rdata = rdata_r;
  assign rd_valid = rd_valid_r;
  assign if_freq = if_freq_r;
  assign bandwidth = bandwidth_r;
  assign tank_inductance = lind_r;
  assign lower_resonator_margin = mlo_r;
  assign upper_resonator_margin = mup_r;
  assign tank_resonator_margin = mtank_r;
  assign feedback_dac_full_scale = dacfs_r;
  assign cal_slot = slot_r;

  // read port and calibration control reserved bits
  a_write_readback: assert property (@(posedge clk) disable iff (!rstn)
    wr_en && hit[IFTCR_MLO] ##1 !wr_en ##1 rd_en && hit[IFTCR_MLO] && !wr_en |=> rdata == $past(wdata, 3))
    else $error("readback mismatch");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!rstn)
    rd_en && hit == '0 |=> rdata == 8'h00 && rd_valid)
    else $error("unmapped read not zero");
  a_rd_valid_pulse: assert property (@(posedge clk) disable iff (!rstn)
    rd_valid == $past(rd_en))
    else $error("read valid not one cycle after read strobe");
  a_rdata_hold: assert property (@(posedge clk) disable iff (!rstn)
    !rd_en |=> $stable(rdata))
    else $error("read data changed without read");
  a_rsvd_read: assert property (@(posedge clk) disable iff (!rstn)
    rd_en && hit[IFTCR_CALC] |=> (rdata & `IFTCR_CAL_CTRL_RSVD_MASK) == 8'h00)
    else $error("calibration control reserved bits read as one");
  a_cal_rsvd: assert property (@(posedge clk) disable iff (!rstn)
    (q[IFTCR_CALC] & `IFTCR_CAL_CTRL_RSVD_MASK) == 8'h00)
    else $error("calibration control reserved bits set");
  a_cal_mask_write: assert property (@(posedge clk) disable iff (!rstn)
    wr_en && hit[IFTCR_CALC] |=> q[IFTCR_CALC] == ($past(wdata) & ~`IFTCR_CAL_CTRL_RSVD_MASK))
    else $error("calibration control write not masked");

  // write path: a written byte reaches its field output two edges later
  a_if_freq_out: assert property (@(posedge clk) disable iff (!rstn)
    wr_en && addr == `IFTCR_OFS_IF_FREQ_LOW |-> ##2 if_freq[7:0] == $past(wdata, 2))
    else $error("if frequency low byte not propagated");
  a_if_hi_out: assert property (@(posedge clk) disable iff (!rstn)
    wr_en && addr == `IFTCR_OFS_IF_FREQ_HIGH |-> ##2 if_freq[15:8] == $past(wdata, 2))
    else $error("if frequency high byte not propagated");
  a_bw_lo_out: assert property (@(posedge clk) disable iff (!rstn)
    wr_en && addr == `IFTCR_OFS_BANDWIDTH_LOW |-> ##2 bandwidth[7:0] == $past(wdata, 2))
    else $error("bandwidth low byte not propagated");
  a_bw_out: assert property (@(posedge clk) disable iff (!rstn)
    wr_en && addr == `IFTCR_OFS_BANDWIDTH_HIGH |-> ##2 bandwidth[15:8] == $past(wdata, 2))
    else $error("bandwidth high byte not propagated");
  a_lind_out: assert property (@(posedge clk) disable iff (!rstn)
    wr_en && addr == `IFTCR_OFS_TANK_INDUCTANCE |-> ##2 tank_inductance == $past(wdata, 2))
    else $error("tank inductance not propagated");
  a_mlo_out: assert property (@(posedge clk) disable iff (!rstn)
    wr_en && addr == `IFTCR_OFS_LOWER_MARGIN |-> ##2 lower_resonator_margin == $past(wdata, 2))
    else $error("lower margin not propagated");
  a_mup_out: assert property (@(posedge clk) disable iff (!rstn)
    wr_en && addr == `IFTCR_OFS_UPPER_MARGIN |-> ##2 upper_resonator_margin == $past(wdata, 2))
    else $error("upper margin not propagated");
  a_mtank_out: assert property (@(posedge clk) disable iff (!rstn)
    wr_en && addr == `IFTCR_OFS_TANK_MARGIN |-> ##2 tank_resonator_margin == $past(wdata, 2))
    else $error("tank margin not propagated");
  a_dac_out: assert property (@(posedge clk) disable iff (!rstn)
    wr_en && addr == `IFTCR_OFS_DAC_FULL_SCALE |-> ##2 feedback_dac_full_scale == $past(wdata, 2))
    else $error("dac code not propagated");
  a_cal_slot: assert property (@(posedge clk) disable iff (!rstn)
    wr_en && addr == `IFTCR_OFS_CAL_CONTROL |-> ##2 cal_slot == $past(wdata[1:0], 2))
    else $error("calibration slot not taken");

  // field outputs hold while their registers are not written
  a_if_hold: assert property (@(posedge clk) disable iff (!rstn)
    !(wr_en && (hit[IFTCR_IF_LO] || hit[IFTCR_IF_HI])) |=> ##1 $stable(if_freq))
    else $error("if frequency changed without write");
  a_bw_hold: assert property (@(posedge clk) disable iff (!rstn)
    !(wr_en && (hit[IFTCR_BW_LO] || hit[IFTCR_BW_HI])) |=> ##1 $stable(bandwidth))
    else $error("bandwidth changed without write");
  a_lind_hold: assert property (@(posedge clk) disable iff (!rstn)
    !(wr_en && hit[IFTCR_LIND]) |=> ##1 $stable(tank_inductance))
    else $error("tank inductance changed without write");
  a_mlo_hold: assert property (@(posedge clk) disable iff (!rstn)
    !(wr_en && hit[IFTCR_MLO]) |=> ##1 $stable(lower_resonator_margin))
    else $error("lower margin changed without write");
  a_margin_hold: assert property (@(posedge clk) disable iff (!rstn)
    !(wr_en && hit[IFTCR_MUP]) |=> ##1 upper_resonator_margin == $past(upper_resonator_margin))
    else $error("upper margin changed without write");
  a_mtank_hold: assert property (@(posedge clk) disable iff (!rstn)
    !(wr_en && hit[IFTCR_MTANK]) |=> ##1 $stable(tank_resonator_margin))
    else $error("tank margin changed without write");
  a_dac_hold: assert property (@(posedge clk) disable iff (!rstn)
    !(wr_en && hit[IFTCR_DACFS]) |=> ##1 $stable(feedback_dac_full_scale))
    else $error("dac code changed without write");
  a_slot_hold: assert property (@(posedge clk) disable iff (!rstn)
    !(wr_en && hit[IFTCR_CALC]) |=> ##1 $stable(cal_slot))
    else $error("calibration slot changed without write");
  a_unmapped_write: assert property (@(posedge clk) disable iff (!rstn)
    wr_en && hit == '0 |=> ##1 $stable(if_freq) && $stable(bandwidth) && $stable(cal_slot))
    else $error("unmapped write changed a field");

  // defaults right after reset release
  a_reset_values: assert property (@(posedge clk) disable iff (!rstn)
    $rose(rstn) |-> if_freq == {`IFTCR_RST_IF_FREQ_HIGH, `IFTCR_RST_IF_FREQ_LOW}
      && bandwidth == {`IFTCR_RST_BANDWIDTH_HIGH, `IFTCR_RST_BANDWIDTH_LOW}
      && tank_inductance == `IFTCR_RST_TANK_INDUCTANCE && lower_resonator_margin == `IFTCR_RST_LOWER_MARGIN
      && upper_resonator_margin == `IFTCR_RST_UPPER_MARGIN && tank_resonator_margin == `IFTCR_RST_TANK_MARGIN
      && feedback_dac_full_scale == `IFTCR_RST_DAC_FULL_SCALE && cal_slot == 2'h0 && !rd_valid)
    else $error("field outputs not at defaults after reset");
endmodule : iftcr_bank
`default_nettype wire

/* File: hw/iftcr_regs.svh */
// constants of the tuning configuration register bank
// assumes an 8-bit register port with 9-bit addresses, one clock
`ifndef IFTCR_REGS_SVH
`define IFTCR_REGS_SVH
`define IFTCR_OFS_IF_FREQ_LOW 9'h102
`define IFTCR_OFS_IF_FREQ_HIGH 9'h103
`define IFTCR_OFS_BANDWIDTH_LOW 9'h104
`define IFTCR_OFS_BANDWIDTH_HIGH 9'h105
`define IFTCR_OFS_TANK_INDUCTANCE 9'h106
`define IFTCR_OFS_LOWER_MARGIN 9'h107
`define IFTCR_OFS_UPPER_MARGIN 9'h108
`define IFTCR_OFS_TANK_MARGIN 9'h109
`define IFTCR_OFS_DAC_FULL_SCALE 9'h10a
`define IFTCR_OFS_CAL_CONTROL 9'h115
`define IFTCR_RST_IF_FREQ_LOW 8'h2c
`define IFTCR_RST_IF_FREQ_HIGH 8'h01
`define IFTCR_RST_BANDWIDTH_LOW 8'h3c
`define IFTCR_RST_BANDWIDTH_HIGH 8'h00
`define IFTCR_RST_TANK_INDUCTANCE 8'h14
`define IFTCR_RST_LOWER_MARGIN 8'h05
`define IFTCR_RST_UPPER_MARGIN 8'h05
`define IFTCR_RST_TANK_MARGIN 8'h00
`define IFTCR_RST_DAC_FULL_SCALE 8'h40
`define IFTCR_RST_CAL_CONTROL 8'h00
`define IFTCR_CAL_SLOT_MSB 1
`define IFTCR_CAL_SLOT_LSB 0
`define IFTCR_CAL_CTRL_RSVD_MASK 8'hfc
`endif

/* File: hw/iftcr_pkg.sv */
// types of the tuning configuration register bank
// assumes nothing beyond the register header
`default_nettype none
package iftcr_pkg;
  typedef logic [7:0] iftcr_byte_t;
  typedef logic [15:0] iftcr_mhz_t;
  typedef logic [1:0] iftcr_slot_t;
  typedef enum logic [3:0] {
    IFTCR_IF_LO = 4'h0,
    IFTCR_IF_HI = 4'h1,
    IFTCR_BW_LO = 4'h2,
    IFTCR_BW_HI = 4'h3,
    IFTCR_LIND = 4'h4,
    IFTCR_MLO = 4'h5,
    IFTCR_MUP = 4'h6,
    IFTCR_MTANK = 4'h7,
    IFTCR_DACFS = 4'h8,
    IFTCR_CALC = 4'h9
  } iftcr_idx_t;
endpackage : iftcr_pkg
`default_nettype wire

/* File: hw/iftcr_cell.sv */
// one 8-bit register cell with write enable, writable-bit mask and reset value
// assumes a single clock and asynchronous active-low reset
`default_nettype none
module iftcr_cell
  import iftcr_pkg::*;
#(
  parameter iftcr_byte_t RST = 8'h00,
  parameter iftcr_byte_t MASK = 8'hff
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic we,
  input wire iftcr_byte_t wdata,
  output iftcr_byte_t q
);
  iftcr_byte_t q_r;
  iftcr_byte_t q_nxt;
  always_comb begin
    q_nxt = q_r;
    if (we) begin
      q_nxt = wdata & MASK;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_r <= RST;
    end else begin
      q_r <= q_nxt;
    end
  end
  assign q = q_r;
endmodule : iftcr_cell
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the tuning configuration register bank
// assumes iftcr_bank drives rdata and rd_valid one cycle after rd_en
`include "iftcr_regs.svh"
`default_nettype none
module tb
  import iftcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, wr_en, rd_en, rd_valid;
  logic [8:0] addr;
  iftcr_byte_t wdata, rdata, tank_inductance, lower_resonator_margin, upper_resonator_margin;
  iftcr_byte_t tank_resonator_margin, feedback_dac_full_scale;
  iftcr_mhz_t if_freq, bandwidth;
  iftcr_slot_t cal_slot;
  int num_errors = 0;
  int n_tests = 0;
  logic [8:0] ofs [10] = '{`IFTCR_OFS_IF_FREQ_LOW, `IFTCR_OFS_IF_FREQ_HIGH, `IFTCR_OFS_BANDWIDTH_LOW,
    `IFTCR_OFS_BANDWIDTH_HIGH, `IFTCR_OFS_TANK_INDUCTANCE, `IFTCR_OFS_LOWER_MARGIN, `IFTCR_OFS_UPPER_MARGIN,
    `IFTCR_OFS_TANK_MARGIN, `IFTCR_OFS_DAC_FULL_SCALE, `IFTCR_OFS_CAL_CONTROL};
  iftcr_byte_t dflt [10] = '{8'h2c, 8'h01, 8'h3c, 8'h00, 8'h14, 8'h05, 8'h05, 8'h00, 8'h40, 8'h00};
  iftcr_byte_t expv [10];
  iftcr_bank i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata),
    .rdata(rdata), .rd_valid(rd_valid), .if_freq(if_freq), .bandwidth(bandwidth),
    .tank_inductance(tank_inductance), .lower_resonator_margin(lower_resonator_margin),
    .upper_resonator_margin(upper_resonator_margin), .tank_resonator_margin(tank_resonator_margin),
    .feedback_dac_full_scale(feedback_dac_full_scale), .cal_slot(cal_slot));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task close_out;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task wr(input logic [8:0] a, input iftcr_byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task rd(input logic [8:0] a, input logic we, output iftcr_byte_t d);
    int k;
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    wr_en <= we;
    @(posedge clk);
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    k = 0;
    #1;
    while (rd_valid !== 1'b1 && k < 4) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (rd_valid !== 1'b1) begin
      num_errors++;
      close_out();
    end
    d = rdata;
  endtask : rd
  // reads every register and compares it and the field outputs with expv
  task chk_regs;
    iftcr_byte_t d;
    for (int i = 0; i < 10; i++) begin
      rd(ofs[i], 1'b0, d);
      chk("readback", d, expv[i]);
    end
    chk("if_freq", if_freq, {expv[1], expv[0]});
    chk("bandwidth", bandwidth, {expv[3], expv[2]});
    chk("tank_inductance", tank_inductance, expv[4]);
    chk("lower_margin", lower_resonator_margin, expv[5]);
    chk("upper_margin", upper_resonator_margin, expv[6]);
    chk("tank_margin", tank_resonator_margin, expv[7]);
    chk("dac_full_scale", feedback_dac_full_scale, expv[8]);
    chk("cal_slot", cal_slot, expv[9][1:0]);
  endtask : chk_regs
  task test_defaults;
    expv = dflt;
    chk_regs();
    $display("test defaults done");
  endtask : test_defaults
  task test_write_all;
    iftcr_byte_t v;
    for (int i = 0; i < 10; i++) begin
      v = 8'hc3 + 8'(i);
      if (i == 3) begin
        v = 8'h00;
      end else if (i == 8) begin
        v = 8'h20;
      end
      wr(ofs[i], v);
      expv[i] = v;
    end
    expv[9] = expv[9] & ~`IFTCR_CAL_CTRL_RSVD_MASK;
    chk_regs();
    wr(`IFTCR_OFS_DAC_FULL_SCALE, 8'h10);
    wr(`IFTCR_OFS_CAL_CONTROL, 8'h02);
    expv[8] = 8'h10;
    expv[9] = 8'h02;
    chk_regs();
    $display("test write all done");
  endtask : test_write_all
  task test_unmapped;
    iftcr_byte_t d;
    logic [8:0] bad [4];
    bad = '{9'h101, 9'h10b, 9'h116, 9'h1ff};
    for (int i = 0; i < 4; i++) begin
      wr(bad[i], 8'h5a);
      rd(bad[i], 1'b0, d);
      chk("unmapped", d, 8'h00);
    end
    chk_regs();
    $display("test unmapped done");
  endtask : test_unmapped
  // write and read in the same cycle: the read returns the old value
  task test_collide;
    iftcr_byte_t d;
    @(posedge clk);
    wdata <= 8'h09;
    rd(`IFTCR_OFS_LOWER_MARGIN, 1'b1, d);
    chk("collide old", d, expv[5]);
    rd(`IFTCR_OFS_LOWER_MARGIN, 1'b0, d);
    chk("collide new", d, 8'h09);
    wr(`IFTCR_OFS_LOWER_MARGIN, 8'h0a);
    rd(`IFTCR_OFS_LOWER_MARGIN, 1'b0, d);
    chk("write then read", d, 8'h0a);
    expv[5] = 8'h0a;
    chk_regs();
    $display("test collide done");
  endtask : test_collide
  task test_reset_again;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    test_defaults();
    $display("test reset again done");
  endtask : test_reset_again
  initial begin
    rstn = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 9'h000;
    wdata = 8'h00;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    test_defaults();
    test_write_all();
    test_unmapped();
    test_collide();
    test_reset_again();
    close_out();
  end
endmodule : tb
`default_nettype wire
